/* pkg/imfl_pkg.sv */
// Constants shared by both ends of the indirect management link.
// Summary of operation
// - Start field 00 marks an indirect frame.
// - Start field 01 frames are ignored entirely.
// - Opcode 00 loads payload into address register.
// - Opcode 01 writes payload to addressed register.
// - Opcode 11 reads the addressed register.
// - Opcode 10 reads then advances the address.
// - Port address is five bits, MSB first.
// - Controller must know port addresses beforehand.
// - Device address is five bits, MSB first.
// - Both release the line in first read turnaround.
// - Device drives zero in second read turnaround.
// - Controller drives 10 turnaround on writes.
// - Sixteen-bit payload shifts MSB first.
// - Device drives whole register during read data; goes quiet if the fetch has not returned.
// - Controller samples device bits on rising clock.
// - Idle drivers release the line to pull-up.
// - Thirty-two ones must precede every frame.
// - Own address register; only address frames overwrite.
// - Increment after read, hold at 65535.
package imfl_pkg;

    localparam int unsigned ID_W   = 5;
    localparam int unsigned DATA_W = 16;

    localparam logic [1:0] ST_INDIRECT = 2'h0;
    localparam logic [1:0] OP_ADDR     = 2'h0;
    localparam logic [1:0] OP_WRITE    = 2'h1;
    localparam logic [1:0] OP_READ     = 2'h3;
    localparam logic [1:0] OP_PRIA     = 2'h2;
    localparam logic [1:0] TA_WRITE    = 2'h2;
    localparam logic [1:0] TA_READ     = 2'h3;

    localparam logic [31:0]       PRE_PATTERN = 32'hFFFFFFFF;
    localparam logic [5:0]        PRE_COUNT   = 6'h20;
    localparam logic [DATA_W-1:0] ADDR_MAX    = 16'hFFFF;
    localparam logic [DATA_W-1:0] ADDR_RST    = 16'h0000;

    // Bit counters of the device, last value of each field.
    localparam logic [3:0] OP_LAST   = 4'h1;
    localparam logic [3:0] ID_LAST   = 4'h4;
    localparam logic [3:0] TA_LAST   = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hF;

    // Bit positions within the 64-bit frame as the controller sends it.
    localparam logic [6:0] TA_POS     = 7'h2E;
    localparam logic [6:0] DATA_POS   = 7'h30;
    localparam logic [6:0] FRAME_LAST = 7'h3F;

    // The clock half period keeps above the 160 ns least high/low time.
    localparam int unsigned REF_PERIOD_NS = 20;
    localparam int unsigned MDC_HALF_NS   = 200;
    localparam logic [3:0]  MDC_HALF_CYC  = 4'((MDC_HALF_NS
        + REF_PERIOD_NS - 1) / REF_PERIOD_NS);

endpackage : imfl_pkg

/* pkg/imfl_if.sv */
// Two-wire management link between the controller and the device.
interface imfl_if;
    logic mdc;
    logic sta_o;
    logic sta_oe;
    logic mmd_o;
    logic mmd_oe;
    logic mdio;

    // Wired line with pull-up: a released driver leaves it high.
    assign mdio = (sta_oe ? sta_o : 1'b1) & (mmd_oe ? mmd_o : 1'b1);

    modport sta (
        output mdc,
        output sta_o,
        output sta_oe,
        input  mdio
    );

    modport mmd (
        input  mdc,
        output mmd_o,
        output mmd_oe,
        input  mdio
    );
endinterface : imfl_if

/* design/imfl_mmd.sv */
// Device end: frame decoder on the link clock, register port on ref_clk.
module imfl_mmd (
    imfl_if.mmd              bus,
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  cfg_prtad,
    input  wire logic [4:0]  cfg_devad,
    output logic             reg_wr_en,
    output logic [15:0]      reg_wr_addr,
    output logic [15:0]      reg_wr_data,
    output logic             reg_rd_en,
    output logic [15:0]      reg_rd_addr,
    input  wire logic [15:0] reg_rd_data
);

    typedef enum logic [2:0] {
        D_PRE, D_ST2, D_OP, D_PRT, D_DEV, D_TA, D_DATA
    } imfl_dstate_t;

    typedef struct packed {
        imfl_dstate_t st;
        logic [5:0]   pre;
        logic [3:0]   cnt;
        logic [1:0]   op;
        logic [4:0]   id;
        logic         port_ok;
        logic         match;
        logic [15:0]  sh;
        logic [15:0]  addr;
        logic         o;
        logic         oe;
        logic         rreq;
        logic         wreq;
        logic [15:0]  raddr;
        logic [15:0]  waddr;
        logic [15:0]  wdata;
        logic         ack_s1;
        logic         ack_s2;
        logic [4:0]   pa_s1;
        logic [4:0]   pa_s2;
        logic [4:0]   da_s1;
        logic [4:0]   da_s2;
    } imfl_link_st_t;

    typedef struct packed {
        logic        rq_s1;
        logic        rq_s2;
        logic        rq_seen;
        logic        wq_s1;
        logic        wq_s2;
        logic        wq_seen;
        logic        rd_en;
        logic [15:0] rd_addr;
        logic        ack;
        logic [15:0] rdata;
        logic        wr_en;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
    } imfl_reg_st_t;

    imfl_link_st_t q;
    imfl_link_st_t d;
    imfl_reg_st_t  rq;
    imfl_reg_st_t  rd;
    logic          m;
    logic          rdop;
    logic [4:0]    id_next;

    assign m       = bus.mdio;
    assign rdop    = q.op[1];
    assign id_next = {q.id[3:0], m};

    // Link side: every field is sampled at the rising link edge and the
    // line is changed at that same edge, so it settles before the next.
    always_comb begin
        d        = q;
        d.ack_s1 = rq.ack;
        d.ack_s2 = q.ack_s1;
        d.pa_s1  = cfg_prtad;
        d.pa_s2  = q.pa_s1;
        d.da_s1  = cfg_devad;
        d.da_s2  = q.da_s1;
        case (q.st)
            D_PRE: begin
                if (m) begin
                    if (q.pre != imfl_pkg::PRE_COUNT) begin
                        d.pre = q.pre + 6'h01;
                    end
                end else if (q.pre == imfl_pkg::PRE_COUNT) begin
                    d.st = D_ST2;
                end else begin
                    d.pre = 6'h00;
                end
            end
            D_ST2: begin
                d.pre = 6'h00;
                d.cnt = 4'h0;
                if (!m) begin
                    d.st = D_OP;
                end else begin
                    // Legacy start: drop back and wait for a new preamble.
                    d.st = D_PRE;
                end
            end
            D_OP: begin
                d.op  = {q.op[0], m};
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == imfl_pkg::OP_LAST) begin
                    d.st  = D_PRT;
                    d.cnt = 4'h0;
                end
            end
            D_PRT: begin
                d.id  = id_next;
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == imfl_pkg::ID_LAST) begin
                    d.st      = D_DEV;
                    d.cnt     = 4'h0;
                    d.port_ok = (id_next == q.pa_s2);
                    // Fetch early: the answer needs several link edges to
                    // cross back before the data field begins.
                    if ((id_next == q.pa_s2) && rdop) begin
                        d.rreq  = ~q.rreq;
                        d.raddr = q.addr;
                    end
                end
            end
            D_DEV: begin
                d.id  = id_next;
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == imfl_pkg::ID_LAST) begin
                    d.st    = D_TA;
                    d.cnt   = 4'h0;
                    d.match = q.port_ok && (id_next == q.da_s2);
                end
            end
            D_TA: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt != imfl_pkg::TA_LAST) begin
                    // Line stayed released through the first bit time.
                    if (q.match && rdop) begin
                        d.oe = 1'b1;
                        d.o  = 1'b0;
                    end
                end else begin
                    d.st  = D_DATA;
                    d.cnt = 4'h0;
                    if (q.match && rdop) begin
                        // Without a returned fetch the device goes quiet
                        // rather than drive a stale word.
                        if (q.ack_s2 == q.rreq) begin
                            d.sh = rq.rdata;
                            d.o  = rq.rdata[15];
                        end else begin
                            d.oe = 1'b0;
                        end
                    end
                end
            end
            D_DATA: begin
                d.sh  = {q.sh[14:0], m};
                d.o   = q.sh[14];
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == imfl_pkg::DATA_LAST) begin
                    d.st  = D_PRE;
                    d.pre = 6'h00;
                    d.oe  = 1'b0;
                    if (q.match) begin
                        case (q.op)
                            imfl_pkg::OP_ADDR: begin
                                d.addr = {q.sh[14:0], m};
                            end
                            imfl_pkg::OP_WRITE: begin
                                d.wreq  = ~q.wreq;
                                d.waddr = q.addr;
                                d.wdata = {q.sh[14:0], m};
                            end
                            imfl_pkg::OP_PRIA: begin
                                if (q.addr != imfl_pkg::ADDR_MAX) begin
                                    d.addr = q.addr + 16'h0001;
                                end
                            end
                            default: begin
                                d.addr = q.addr;
                            end
                        endcase
                    end
                end
            end
            default: begin
                d.st = D_PRE;
            end
        endcase
    end

    always_ff @(posedge bus.mdc or negedge resetn) begin
        if (!resetn) begin
            q      <= '0;
            q.st   <= D_PRE;
            q.addr <= imfl_pkg::ADDR_RST;
        end else begin
            q <= d;
        end
    end

    // Register side: toggles cross by two flops; the words they announce
    // are held still on the link side until the next frame.
    always_comb begin
        rd       = rq;
        rd.rq_s1 = q.rreq;
        rd.rq_s2 = rq.rq_s1;
        rd.wq_s1 = q.wreq;
        rd.wq_s2 = rq.wq_s1;
        rd.rd_en = 1'b0;
        rd.wr_en = 1'b0;
        if (rq.rq_s2 != rq.rq_seen) begin
            rd.rq_seen = rq.rq_s2;
            rd.rd_en   = 1'b1;
            rd.rd_addr = q.raddr;
        end
        if (rq.rd_en) begin
            rd.rdata = reg_rd_data;
            rd.ack   = ~rq.ack;
        end
        if (rq.wq_s2 != rq.wq_seen) begin
            rd.wq_seen = rq.wq_s2;
            rd.wr_en   = 1'b1;
            rd.wr_addr = q.waddr;
            rd.wr_data = q.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rq <= '0;
        end else begin
            rq <= rd;
        end
    end

    assign bus.mmd_o  = q.o;
    assign bus.mmd_oe = q.oe;
    assign reg_wr_en   = rq.wr_en;
    assign reg_wr_addr = rq.wr_addr;
    assign reg_wr_data = rq.wr_data;
    assign reg_rd_en   = rq.rd_en;
    assign reg_rd_addr = rq.rd_addr;

endmodule : imfl_mmd

/* design/imfl_sta.sv */
// Controller end: builds frames and drives the link clock from ref_clk.
module imfl_sta (
    imfl_if.sta              bus,
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [1:0]  cmd_op,
    input  wire logic [4:0]  cmd_prtad,
    input  wire logic [4:0]  cmd_devad,
    input  wire logic [15:0] cmd_data,
    output logic             rsp_valid,
    output logic [15:0]      rsp_data
);

    typedef enum logic [1:0] {H_IDLE, H_RUN, H_DONE} imfl_hstate_t;

    typedef struct packed {
        imfl_hstate_t st;
        logic [3:0]   div;
        logic [6:0]   idx;
        logic [63:0]  frame;
        logic         rd;
        logic [15:0]  rdata;
        logic         mdc;
        logic         o;
        logic         oe;
        logic         ready;
        logic         rsp_v;
        logic [15:0]  rsp_d;
        logic         s1;
        logic         s2;
    } imfl_host_st_t;

    localparam imfl_host_st_t HOST_RST = '{st: H_IDLE, ready: 1'b1,
                                           default: '0};

    imfl_host_st_t q;
    imfl_host_st_t d;
    logic [6:0]    idx_next;

    assign idx_next = q.idx + 7'h01;

    always_comb begin
        d       = q;
        d.rsp_v = 1'b0;
        d.s1    = bus.mdio;
        d.s2    = q.s1;
        case (q.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    // Port address comes from the user as given.
                    d.frame = {imfl_pkg::PRE_PATTERN,
                               imfl_pkg::ST_INDIRECT, cmd_op,
                               cmd_prtad, cmd_devad,
                               cmd_op[1] ? imfl_pkg::TA_READ
                                         : imfl_pkg::TA_WRITE,
                               cmd_data};
                    d.rd    = cmd_op[1];
                    d.o     = 1'b1;
                    d.oe    = 1'b1;
                    d.ready = 1'b0;
                    d.div   = 4'h0;
                    d.idx   = 7'h00;
                    d.rdata = 16'h0000;
                    d.st    = H_RUN;
                end
            end
            H_RUN: begin
                if (q.div == imfl_pkg::MDC_HALF_CYC - 4'h1) begin
                    d.div = 4'h0;
                    if (!q.mdc) begin
                        d.mdc = 1'b1;
                        // Synced level is from well before this edge, when
                        // the device bit has long settled.
                        if (q.rd && (q.idx >= imfl_pkg::DATA_POS)) begin
                            d.rdata = {q.rdata[14:0], q.s2};
                        end
                    end else begin
                        d.mdc = 1'b0;
                        if (q.idx == imfl_pkg::FRAME_LAST) begin
                            d.oe = 1'b0;
                            d.st = H_DONE;
                        end else begin
                            d.idx   = idx_next;
                            d.frame = {q.frame[62:0], 1'b0};
                            d.o     = q.frame[62];
                            d.oe    = !(q.rd && (idx_next >=
                                      imfl_pkg::TA_POS));
                        end
                    end
                end else begin
                    d.div = q.div + 4'h1;
                end
            end
            H_DONE: begin
                d.rsp_v = 1'b1;
                d.rsp_d = q.rdata;
                d.ready = 1'b1;
                d.st    = H_IDLE;
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    assign bus.mdc    = q.mdc;
    assign bus.sta_o  = q.o;
    assign bus.sta_oe = q.oe;
    assign cmd_ready  = q.ready;
    assign rsp_valid  = q.rsp_v;
    assign rsp_data   = q.rsp_d;

endmodule : imfl_sta

/* dv/imfl_sva.sv */
// Checker for the wire side of the management link.
module imfl_sva (
    input wire logic mdc,
    input wire logic resetn,
    input wire logic sta_o,
    input wire logic sta_oe,
    input wire logic mmd_o,
    input wire logic mmd_oe,
    input wire logic mdio
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bit position in the frame; the link clock only ticks inside frames.
    logic [6:0] pos_q;
    logic       rd_q;

    always_ff @(posedge mdc or negedge resetn) begin
        if (!resetn) begin
            pos_q <= 7'h00;
            rd_q  <= 1'b0;
        end else begin
            pos_q <= (pos_q == imfl_pkg::FRAME_LAST) ? 7'h00 : pos_q + 7'h01;
            if (pos_q == 7'h22) begin
                rd_q <= mdio;
            end
        end
    end

    default clocking cb @(posedge mdc);
    endclocking
    default disable iff (!resetn);

    a_pre_ones:
    assert property (pos_q < 7'h20 |-> sta_oe && mdio)
        else $error("Preamble bit not a driven one");
    a_start_zero:
    assert property ((pos_q == 7'h20 || pos_q == 7'h21) |-> sta_oe && !mdio)
        else $error("Start bit not a driven zero");
    a_ta1_release:
    assert property (pos_q == 7'h2E && rd_q |-> !sta_oe && !mmd_oe && mdio)
        else $error("First turnaround bit was driven");
    a_ta2_zero:
    assert property (pos_q == 7'h2F && rd_q && mmd_oe |-> !mmd_o && !mdio)
        else $error("Second read turnaround bit not zero");
    a_wr_ta:
    assert property (pos_q == 7'h2E && !rd_q |->
        sta_oe && sta_o ##1 sta_oe && !sta_o)
        else $error("Write turnaround not one then zero");
    a_dev_quiet:
    assert property (pos_q < 7'h2E || !rd_q |-> !mmd_oe)
        else $error("Device drove outside a read answer");
    a_read_release:
    assert property (pos_q >= 7'h2E && rd_q |-> !sta_oe)
        else $error("Controller drove during a read answer");
    a_hold_data:
    assert property (pos_q == 7'h2F && mmd_oe |->
        ##1 mmd_oe [*8] ##1 mmd_oe [*8] ##1 !mmd_oe)
        else $error("Device answer not sixteen bits long");
    a_pull_up:
    assert property (pos_q >= 7'h30 && rd_q && !mmd_oe |-> mdio)
        else $error("Released line not high");
endmodule : imfl_sva

/* dv/indirect_mdio_frame_logic_tb.sv */
// Bench joining both link ends, plus a rule-breaking driver on a spare link.
`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
        end \
    end

module indirect_mdio_frame_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk;
    logic        resetn;
    logic [4:0]  cfg_prtad;
    logic [4:0]  cfg_devad;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [1:0]  cmd_op;
    logic [4:0]  cmd_prtad;
    logic [4:0]  cmd_devad;
    logic [15:0] cmd_data;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        reg_wr_en;
    logic        reg_rd_en;
    logic [15:0] reg_wr_addr;
    logic [15:0] reg_wr_data;
    logic [15:0] reg_rd_addr;
    logic [15:0] reg_rd_data;
    logic        aux_wr_en;
    logic [15:0] aux_wr_data;
    logic [63:0] wire_q;
    logic [15:0] amod;
    logic [15:0] wr_addr_s;
    logic [15:0] wr_data_s;
    logic        aux_drv;
    logic [31:0] r;
    int          error_cnt = 0;
    int          check_count = 0;
    int          wr_cnt = 0;
    int          rd_cnt = 0;
    int          aux_cnt = 0;
    int          cyc = 0;
    int          seed;

    // Register contents behind the device: a fixed scramble of the address.
    function automatic logic [15:0] rd_val(input logic [15:0] a);
        return {a[7:0], ~a[15:8]};
    endfunction : rd_val

    assign reg_rd_data = rd_val(reg_rd_addr);

    imfl_if link_if ();
    imfl_if rogue_if ();

    imfl_sta imfl_sta_inst (.bus(link_if.sta), .ref_clk(ref_clk),
        .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_prtad(cmd_prtad), .cmd_devad(cmd_devad),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    imfl_mmd imfl_mmd_inst (.bus(link_if.mmd), .ref_clk(ref_clk),
        .resetn(resetn), .cfg_prtad(cfg_prtad), .cfg_devad(cfg_devad),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data));
    imfl_mmd imfl_mmd_aux_inst (.bus(rogue_if.mmd), .ref_clk(ref_clk),
        .resetn(resetn), .cfg_prtad(cfg_prtad), .cfg_devad(cfg_devad),
        .reg_wr_en(aux_wr_en), .reg_wr_addr(), .reg_wr_data(aux_wr_data),
        .reg_rd_en(), .reg_rd_addr(), .reg_rd_data(16'h0000));
    imfl_sva imfl_sva_inst (.mdc(link_if.mdc), .resetn(resetn),
        .sta_o(link_if.sta_o), .sta_oe(link_if.sta_oe),
        .mmd_o(link_if.mmd_o), .mmd_oe(link_if.mmd_oe), .mdio(link_if.mdio));

    always #10 ref_clk = ~ref_clk;

    always @(posedge link_if.mdc) begin
        wire_q = {wire_q[62:0], link_if.mdio};
    end

    always @(posedge rogue_if.mmd_oe) begin
        aux_drv = 1'b1;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (reg_wr_en === 1'b1) begin
            wr_cnt++;
            wr_addr_s = reg_wr_addr;
            wr_data_s = reg_wr_data;
        end
        if (aux_wr_en === 1'b1) begin
            aux_cnt++;
        end
        if (reg_rd_en === 1'b1) begin
            rd_cnt++;
        end
        // About 33 frames of 1283 cycles each, with ample margin.
        if (cyc == 60000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic frame(input logic [1:0] op, input logic [4:0] p,
                         input logic [4:0] d, input logic [15:0] v);
        logic        hit;
        logic [15:0] er;
        logic [63:0] ew;
        int          n0;
        int          k;
        int          n1;
        hit = (p === cfg_prtad) && (d === cfg_devad);
        er = op[1] ? (hit ? rd_val(amod) : 16'hFFFF) : 16'h0000;
        ew = {imfl_pkg::PRE_PATTERN, imfl_pkg::ST_INDIRECT, op, p, d,
              (op[1] && !hit) ? 2'h3 : 2'h2, op[1] ? er : v};
        n0 = wr_cnt;
        n1 = rd_cnt;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_prtad = p;
        cmd_devad = d;
        cmd_data = v;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (cmd_ready !== 1'b0 && k < 10);
        cmd_valid = 1'b0;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (rsp_valid !== 1'b1 && k < 1400);
        `CHK("rsp_valid", 1'b1, rsp_valid);
        `CHK("cmd_ready", 1'b1, cmd_ready);
        `CHK("rsp_data", er, rsp_data);
        `CHK("wire", ew, wire_q);
        `CHK("writes", (op == imfl_pkg::OP_WRITE && hit) ? 1 : 0,
             wr_cnt - n0);
        // A read is fetched as soon as the port matches, before the
        // device address is known, so one fetch per port-matching read.
        `CHK("reads", (op[1] && (p === cfg_prtad)) ? 1 : 0,
             rd_cnt - n1);
        if (op == imfl_pkg::OP_WRITE && hit) begin
            `CHK("wr_addr", amod, wr_addr_s);
            `CHK("wr_data", v, wr_data_s);
        end
        if (hit && op == imfl_pkg::OP_ADDR) begin
            amod = v;
        end
        if (hit && op == imfl_pkg::OP_PRIA
            && amod !== imfl_pkg::ADDR_MAX) begin
            amod = amod + 16'h0001;
        end
        $display("Frame op %b port %h dev %h done", op, p, d);
    endtask : frame

    // Bit-bangs one frame on the spare link; the clock stands still after.
    task automatic rogue(input logic [63:0] f);
        #3.3;
        rogue_if.sta_oe = 1'b1;
        for (int i = 63; i >= 0; i--) begin
            rogue_if.sta_o = f[i];
            #7.5 rogue_if.mdc = 1'b1;
            #7.5 rogue_if.mdc = 1'b0;
        end
        rogue_if.sta_oe = 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask : rogue

    initial begin
        seed = 3854;
        ref_clk = 1'b0;
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_prtad = 5'h00;
        cmd_devad = 5'h00;
        cmd_data = 16'h0000;
        cfg_prtad = 5'($random(seed));
        cfg_devad = 5'($random(seed));
        rogue_if.mdc = 1'b0;
        rogue_if.sta_o = 1'b0;
        rogue_if.sta_oe = 1'b0;
        amod = imfl_pkg::ADDR_RST;
        repeat (3) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        frame(imfl_pkg::OP_READ, cfg_prtad, cfg_devad, 16'h0000);
        frame(imfl_pkg::OP_ADDR, cfg_prtad, cfg_devad, 16'hFFFE);
        frame(imfl_pkg::OP_PRIA, cfg_prtad, cfg_devad, 16'h0000);
        frame(imfl_pkg::OP_PRIA, cfg_prtad, cfg_devad, 16'h0000);
        frame(imfl_pkg::OP_READ, cfg_prtad, cfg_devad, 16'h0000);
        frame(imfl_pkg::OP_ADDR, cfg_prtad ^ 5'h01, cfg_devad, 16'h1234);
        frame(imfl_pkg::OP_WRITE, cfg_prtad, cfg_devad ^ 5'h10, 16'hBEEF);
        frame(imfl_pkg::OP_READ, ~cfg_prtad, cfg_devad, 16'h0000);
        frame(imfl_pkg::OP_WRITE, cfg_prtad, cfg_devad, 16'h8001);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            frame(r[1:0], (r[4:2] == 3'h0) ? r[9:5] : cfg_prtad,
                  (r[12:10] == 3'h0) ? r[17:13] : cfg_devad, r[31:16]);
        end
        aux_drv = 1'b0;
        rogue({32'hFFFFFFFF, 2'h1, 2'h3, cfg_prtad, cfg_devad, 18'h3FFFF});
        rogue({32'hFFFFFFFF, 2'h1, 2'h1, cfg_prtad, cfg_devad, 18'h20000});
        rogue({32'h7FFFFFFF, 2'h0, 2'h1, cfg_prtad, cfg_devad, 18'h20000});
        `CHK("aux_drive", 1'b0, aux_drv);
        `CHK("aux_writes", 0, aux_cnt);
        rogue({32'hFFFFFFFF, 2'h0, 2'h1, cfg_prtad, cfg_devad, 18'h2C35A});
        `CHK("aux_writes", 1, aux_cnt);
        `CHK("aux_data", 16'hC35A, aux_wr_data);
        $display("Spare link frames done");
        finish_test();
    end
endmodule : indirect_mdio_frame_logic_tb
